/* common/ppam_pkg.sv */
// Constants, types and helpers shared by the program page address mapper.
`default_nettype none
package ppam_pkg;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] PPAM_IDX_PAGE = 8'h15;
	localparam logic [7:0] PPAM_IDX_DBG_PAGE = 8'h16;
	localparam logic [7:0] PPAM_IDX_STATUS = 8'h17;
	localparam int PPAM_ADDR_W = 10;
	localparam logic [3:0] PPAM_PAGE_RESET = 4'hE;
	localparam logic [3:0] PPAM_DBG_PAGE_RESET = 4'h0;
	// Fixed pages of the local map.
	localparam logic [3:0] PPAM_PAGE_LOW = 4'hC;
	localparam logic [3:0] PPAM_PAGE_MID = 4'hD;
	localparam logic [3:0] PPAM_PAGE_TOP = 4'hF;
	localparam logic [3:0] PPAM_PAGE_NVM = 4'h1;
	localparam logic [1:0] PPAM_WIN_LOW = 2'h0;
	localparam logic [1:0] PPAM_WIN_MID = 2'h1;
	localparam logic [1:0] PPAM_WIN_PAGED = 2'h2;
	// Debug resource windows in the local map.
	localparam logic [7:0] PPAM_DBG_TOP_HI = 8'hFF;
	localparam logic [7:0] PPAM_DBG_PAGED_HI = 8'hBF;
	// Global implemented areas.
	localparam logic [17:0] PPAM_REGS_TOP = 18'h003FF;
	localparam logic [17:0] PPAM_RAM_END = 18'h03FFF;
	localparam logic [17:0] PPAM_RAM_LIMIT = 18'h04000;
	localparam logic [17:0] PPAM_DFL_BOT = 18'h04400;
	localparam logic [17:0] PPAM_DFL_TOP = 18'h053FF;
	localparam logic [18:0] PPAM_PF_LIMIT = 19'h40000;
	localparam int PPAM_RAM_BYTES = 6144;
	localparam int PPAM_FLASH_BYTES = 65536;
	// Debug master starves on the stalled cycle after this many have been counted.
	localparam logic [7:0] PPAM_STARVE_LIMIT = 8'h80;
	// Status register bit positions.
	localparam int PPAM_ST_ILLEGAL = 0;
	localparam int PPAM_ST_SPECIAL = 1;
	localparam int PPAM_ST_DEBUG = 2;
	localparam int PPAM_ST_STARVE = 3;

	typedef enum logic [1:0] {
		PPAM_M_NONE = 2'b00,
		PPAM_M_CPU = 2'b01,
		PPAM_M_DBG = 2'b10
	} ppam_master_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic fw_cmd;
		logic [15:0] addr;
	} ppam_req_s;

	typedef struct packed {
		logic valid;
		ppam_master_e master;
		logic write;
		logic [17:0] gaddr;
		logic sel_regs;
		logic sel_ram;
		logic sel_dflash;
		logic sel_nvm;
		logic sel_pflash;
		logic sel_debug;
		logic unimpl;
	} ppam_tgt_s;

	// Local to global expansion: page number above the low fourteen bits.
	function automatic logic [17:0] ppam_expand(input logic [15:0] a,
			input logic [3:0] page);
		logic [3:0] p;
		p = PPAM_PAGE_TOP;
		case (a[15:14])
			PPAM_WIN_LOW: p = PPAM_PAGE_LOW;
			PPAM_WIN_MID: p = PPAM_PAGE_MID;
			PPAM_WIN_PAGED: p = page;
			default: p = PPAM_PAGE_TOP;
		endcase
		return {p, a[13:0]};
	endfunction
endpackage
`default_nettype wire

/* src/ppam_mapper.sv */
// Program page address mapper: local to global expansion and target select.
// Operation
// R01 - Page index: four bits, upper bits zero.
// R02 - Window 0x8000-0xBFFF uses page index.
// R03 - Page index resets to 0x0E.
// R04 - Local 0x0000-0x3FFF is page 0x0C.
// R05 - Local 0x4000-0x7FFF is page 0x0D.
// R06 - Local 0xC000-0xFFFF is page 0x0F.
// R07 - CPU call/return path writes page index.
// R08 - Normal and special single-chip modes.
// R09 - Debug resources only in debug cycles.
// R10 - Debug resources at 0xFF00-0xFFFF when active.
// R11 - Debug also at 0xBF00-0xBFFF if page 0x0F.
// R12 - Debug expands alike; debug page when enabled.
// R13 - Registers at global 0x0_0000-0x0_03FF.
// R14 - RAM ends 0x0_3FFF, sized by parameter.
// R15 - Data flash at 0x0_4400-0x0_53FF.
// R16 - Program flash ends 0x3_FFFF, sized by parameter.
// R17 - Auxiliary resources through page 0x01.
// R18 - CPU unimplemented access raises illegal reset.
// R19 - Debug unimplemented access completes, no reset.
// R20 - Debug unit never sends misaligned words.
// R21 - CPU first; debug wins after 128 stalls (the code grants debug after 129).
// R22 - Global is page above low fourteen bits.
// R23 - Memory sizes are design parameters.
`default_nettype none
module ppam_mapper
	import ppam_pkg::*;
#(
	parameter int RAM_BYTES = PPAM_RAM_BYTES,
	parameter int FLASH_BYTES = PPAM_FLASH_BYTES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Mode and debug state
	input wire logic special_mode,
	input wire logic debug_active,
	input wire logic dbg_page_en,
	// CPU master
	input wire ppam_req_s cpu_req,
	input wire logic call_page_we,
	input wire logic [3:0] call_page_data,
	output logic cpu_grant,
	// Debug master
	input wire ppam_req_s dbg_req,
	output logic dbg_grant,
	// Target side
	output ppam_tgt_s tgt,
	output logic illegal_reset,
	output logic [3:0] program_page_select
);
	localparam logic [17:0] RAM_BOT = PPAM_RAM_LIMIT - 18'(RAM_BYTES); // R14 R23
	localparam logic [18:0] PF_BOT19 = PPAM_PF_LIMIT - 19'(FLASH_BYTES); // R16 R23
	localparam logic [17:0] PF_BOT = PF_BOT19[17:0];

	typedef struct packed {
		logic [3:0] page;
		logic [3:0] dbg_page;
		logic [7:0] stall;
		logic starve;
		logic illegal_seen;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic cpu_grant;
		logic dbg_grant;
		ppam_tgt_s tgt;
		logic illegal_reset;
	} ppam_state_s;

	ppam_state_s s_q;
	ppam_state_s s_d;

	logic apb_done;
	logic [PPAM_ADDR_W-1:0] reg_idx;
	logic idx_ok;
	logic use_dbg;
	ppam_req_s req;
	logic [3:0] eff_page;
	logic [17:0] gaddr;
	logic dbg_cycle;
	logic dbg_hit;

	assign apb_done = psel & penable & s_q.pready;
	assign reg_idx = paddr[PPAM_ADDR_W+1:2];
	assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[31:PPAM_ADDR_W+2] == '0);

	// Arbitration: the CPU normally wins; a starved debug master takes over.
	always_comb begin
		use_dbg = 1'b0;
		if (dbg_req.valid && (!cpu_req.valid || s_q.starve)) begin // R21
			use_dbg = 1'b1;
		end
		req = use_dbg ? dbg_req : cpu_req;
	end

	// Page selection for the paged window.
	always_comb begin
		eff_page = s_q.page; // R02
		if (dbg_page_en && debug_active && (use_dbg || cpu_req.fw_cmd)) begin
			eff_page = s_q.dbg_page; // R12
		end
		gaddr = ppam_expand(req.addr, eff_page); // R04 R05 R06 R22
	end

	// Debug resources appear only for debug cycles while debug is active.
	always_comb begin
		dbg_cycle = debug_active && (use_dbg || cpu_req.fw_cmd); // R09
		dbg_hit = 1'b0;
		if (dbg_cycle) begin
			if (req.addr[15:8] == PPAM_DBG_TOP_HI) begin
				dbg_hit = 1'b1; // R10
			end else if (req.addr[15:8] == PPAM_DBG_PAGED_HI &&
					eff_page == PPAM_PAGE_TOP) begin
				dbg_hit = 1'b1; // R11
			end
		end
	end

	always_comb begin
		ppam_tgt_s t;
		logic any;
		t = '0;
		any = 1'b0;
		s_d = s_q;
		s_d.illegal_reset = 1'b0;
		s_d.cpu_grant = 1'b0;
		s_d.dbg_grant = 1'b0;

		// APB: one wait state, then the answer stands for one cycle.
		s_d.pready = psel & penable & ~s_q.pready;
		if (psel && penable && !s_q.pready) begin
			s_d.pslverr = 1'b0;
			s_d.prdata = '0;
			if (!idx_ok) begin
				s_d.pslverr = 1'b1;
			end else if (reg_idx == PPAM_ADDR_W'(PPAM_IDX_PAGE)) begin
				s_d.prdata = {28'h0000000, s_q.page}; // R01
			end else if (reg_idx == PPAM_ADDR_W'(PPAM_IDX_DBG_PAGE)) begin
				s_d.prdata = {28'h0000000, s_q.dbg_page};
			end else if (reg_idx == PPAM_ADDR_W'(PPAM_IDX_STATUS)) begin
				s_d.prdata[PPAM_ST_ILLEGAL] = s_q.illegal_seen;
				s_d.prdata[PPAM_ST_SPECIAL] = special_mode; // R08
				s_d.prdata[PPAM_ST_DEBUG] = debug_active;
				s_d.prdata[PPAM_ST_STARVE] = s_q.starve;
			end else begin
				s_d.pslverr = 1'b1;
			end
		end
		if (apb_done && pwrite && idx_ok) begin
			if (reg_idx == PPAM_ADDR_W'(PPAM_IDX_PAGE)) begin
				s_d.page = pwdata[3:0]; // R01
			end else if (reg_idx == PPAM_ADDR_W'(PPAM_IDX_DBG_PAGE)) begin
				s_d.dbg_page = pwdata[3:0];
			end else if (reg_idx == PPAM_ADDR_W'(PPAM_IDX_STATUS) &&
					pwdata[PPAM_ST_ILLEGAL]) begin
				s_d.illegal_seen = 1'b0;
			end
		end
		// The call/return path wins over a bus write in the same cycle so
		// the instruction always sees its own page.
		if (call_page_we) begin
			s_d.page = call_page_data; // R07
		end

		// Starvation counter for the debug master.
		if (dbg_req.valid && !use_dbg) begin
			if (s_q.stall != PPAM_STARVE_LIMIT) begin
				s_d.stall = s_q.stall + 8'h01;
			end else begin
				s_d.starve = 1'b1; // R21
			end
		end else if (use_dbg) begin
			s_d.stall = '0;
			s_d.starve = 1'b0;
		end

		// Target decode of the granted access.
		if (req.valid) begin
			t.valid = 1'b1;
			t.master = use_dbg ? PPAM_M_DBG : PPAM_M_CPU;
			t.write = req.write;
			t.gaddr = gaddr;
			if (dbg_hit) begin
				t.sel_debug = 1'b1; // R10
			end else if (gaddr <= PPAM_REGS_TOP) begin
				t.sel_regs = 1'b1; // R13
			end else if (gaddr >= RAM_BOT && gaddr <= PPAM_RAM_END) begin
				t.sel_ram = 1'b1; // R14
			end else if (gaddr >= PPAM_DFL_BOT && gaddr <= PPAM_DFL_TOP) begin
				t.sel_dflash = 1'b1; // R15
			end else if (gaddr[17:14] == PPAM_PAGE_NVM) begin
				t.sel_nvm = 1'b1; // R17
			end else if (gaddr >= PF_BOT) begin
				t.sel_pflash = 1'b1; // R16
			end
			any = t.sel_debug | t.sel_regs | t.sel_ram | t.sel_dflash |
				t.sel_nvm | t.sel_pflash;
			t.unimpl = ~any;
			s_d.cpu_grant = ~use_dbg;
			s_d.dbg_grant = use_dbg;
			// Debug accesses, and firmware accesses while debug is active, to holes complete quietly.
			if (!any && !use_dbg && !(cpu_req.fw_cmd && debug_active)) begin
				s_d.illegal_reset = 1'b1; // R18
				s_d.illegal_seen = 1'b1;
			end // R19 R20
		end
		s_d.tgt = t;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.page <= PPAM_PAGE_RESET; // R03
			s_q.dbg_page <= PPAM_DBG_PAGE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign pready = s_q.pready;
	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr;
	assign cpu_grant = s_q.cpu_grant;
	assign dbg_grant = s_q.dbg_grant;
	assign tgt = s_q.tgt;
	assign illegal_reset = s_q.illegal_reset;
	assign program_page_select = s_q.page;
endmodule
`default_nettype wire

/* verif/ppam_dbg_master.sv */
// Debug master model: holds each request until it is granted.
`default_nettype none
module ppam_dbg_master
	import ppam_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Bench command
	input wire logic start,
	input wire logic [15:0] addr,
	// Mapper side
	input wire logic dbg_grant,
	output ppam_req_s dbg_req
);
	always_ff @(posedge clk) begin
		if (reset)
			dbg_req <= '0;
		else if (start && !dbg_req.valid)
			dbg_req <= '{1'b1, 1'b0, 1'b0, {addr[15:1], 1'b0}};
		else if (dbg_grant) begin
			// A released address changes, so stale values cannot pass.
			dbg_req.valid <= 1'b0;
			dbg_req.addr <= ~dbg_req.addr;
		end
	end
endmodule
`default_nettype wire

/* verif/ppam_mapper_props.sv */
// Checker of the program page address mapper port behaviour.
`default_nettype none
module ppam_mapper_props
	import ppam_pkg::*;
#(
	parameter int RAM_BYTES = PPAM_RAM_BYTES,
	parameter int FLASH_BYTES = PPAM_FLASH_BYTES
) (
	// Clock, reset and bus
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Masters
	input wire logic debug_active,
	input wire ppam_req_s cpu_req,
	input wire ppam_req_s dbg_req,
	input wire logic call_page_we,
	input wire logic [3:0] call_page_data,
	// Target side
	input wire ppam_tgt_s tgt,
	input wire logic illegal_reset,
	input wire logic [3:0] program_page_select
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic cpu_only;
	assign cpu_only = cpu_req.valid && !dbg_req.valid && !call_page_we;
	sequence apb_access;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence cpu_in(logic w);
		cpu_only && cpu_req.addr[15] == w;
	endsequence
	a_page_reset: assert property ($fell(reset) |->
		program_page_select == 4'hE) else $error("bad page after reset");
	a_call_write: assert property (call_page_we |=>
		program_page_select == $past(call_page_data)) else $error("call lost");
	a_fixed_low: assert property (cpu_in(1'b0) |=>
		tgt.gaddr == {3'h6, $past(cpu_req.addr[14:0])}) else $error("low page");
	a_paged_top: assert property (cpu_in(1'b1) |=> tgt.gaddr ==
		{$past(cpu_req.addr[14]) ? 4'hF : $past(program_page_select),
		$past(cpu_req.addr[13:0])}) else $error("upper page");
	a_dbg_hidden: assert property (!debug_active |=> !tgt.sel_debug)
		else $error("debug visible");
	a_dbg_window: assert property (debug_active && dbg_req.valid &&
		!cpu_req.valid && dbg_req.addr[15:8] == 8'hFF |=> tgt.sel_debug &&
		!tgt.sel_pflash) else $error("debug window");
	a_dbg_no_reset: assert property (tgt.valid &&
		tgt.master == PPAM_M_DBG |-> !illegal_reset) else $error("dbg reset");
	a_apb_answer: assert property (apb_access |=> pready)
		else $error("no answer");
endmodule
bind ppam_mapper ppam_mapper_props #(.RAM_BYTES(RAM_BYTES),
	.FLASH_BYTES(FLASH_BYTES)) props_u (.clk(clk), .reset(reset),
	.psel(psel), .penable(penable), .pready(pready),
	.debug_active(debug_active), .cpu_req(cpu_req), .dbg_req(dbg_req),
	.call_page_we(call_page_we), .call_page_data(call_page_data),
	.tgt(tgt), .illegal_reset(illegal_reset),
	.program_page_select(program_page_select));
`default_nettype wire

/* verif/ppam_mapper_test.sv */
// Self-checking bench of the program page address mapper.
`default_nettype none
module ppam_mapper_test import ppam_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, dbg_grant, illegal_reset, err, start = 0;
	logic debug_active = 0, call_page_we = 0;
	logic special_mode = 0, dbg_page_en = 0;
	logic [3:0] call_page_data = 4'h0, page, pps;
	logic [15:0] dbg_addr = 16'h0;
	logic [31:0] paddr = 0, pwdata = 0, rd, r, prdata, seed = 32'h16;
	int num_errors = 0, n_compared = 0, waited;
	ppam_req_s cpu_req = '0, dbg_req;
	ppam_tgt_s tgt;
	ppam_mapper dut_u (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.special_mode(special_mode), .debug_active(debug_active),
		.dbg_page_en(dbg_page_en),
		.cpu_req(cpu_req), .call_page_we(call_page_we),
		.call_page_data(call_page_data), .cpu_grant(), .dbg_req(dbg_req),
		.dbg_grant(dbg_grant), .tgt(tgt), .illegal_reset(illegal_reset),
		.program_page_select(pps));
	ppam_dbg_master dbg_u (.clk(clk), .reset(reset), .start(start),
		.addr(dbg_addr), .dbg_grant(dbg_grant), .dbg_req(dbg_req));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [17:0] exp_g(logic [15:0] a);
		return {a[15] ? (a[14] ? 4'hF : page) : {3'h6, a[14]}, a[13:0]};
	endfunction
	function automatic logic exp_ill(logic [17:0] g);
		if (g[17:14] == 4'h0)
			return g > 18'h003FF && g < 18'h04000 - 18'(PPAM_RAM_BYTES);
		return g[17:14] > 4'h1 && g < 18'h40000 - 18'(PPAM_FLASH_BYTES);
	endfunction
	task automatic apb(logic w, logic [31:0] a, d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// Ready is looked at where it is settled; the transfer ends on the
		// rising edge that follows.
		do @(negedge clk); while (pready !== 1'b1);
		@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic cpu(logic [15:0] a);
		@(posedge clk);
		cpu_req <= '{1'b1, r[0], 1'b0, a};
		@(posedge clk);
		cpu_req.valid <= 0;
		#1;
		`CHK(tgt.gaddr, exp_g(a))
		`CHK(illegal_reset, exp_ill(exp_g(a)))
	endtask
	// The target is read at the granting edge, before a repeat take lands.
	task automatic dbg(logic [15:0] a, logic sel, logic act);
		@(posedge clk);
		debug_active <= act;
		start <= 1;
		dbg_addr <= a;
		waited = 0;
		do begin @(posedge clk); start <= 0; #1; waited++; end
		while (dbg_grant !== 1'b1);
		`CHK(tgt.sel_debug, sel)
		`CHK(illegal_reset, 1'b0)
	endtask
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial forever #2 clk = ~clk;
	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge clk);
		reset <= 0;
		page = 4'hE;
		apb(0, 32'h54, 0);
		`CHK(rd, 32'hE)
		`CHK(err, 1'b0)
		apb(1, 32'h54, 32'hFFFFFFF3);
		apb(0, 32'h54, 0);
		page = 4'h3;
		`CHK(rd, 32'h3)
		apb(0, 32'h100, 0);
		`CHK(err, 1'b1)
		special_mode <= 1;
		apb(0, 32'h5C, 0);
		`CHK(rd[1], 1'b1)
		apb(1, 32'h58, 32'h5);
		dbg_page_en <= 1;
		dbg(16'h8123, 0, 1);
		`CHK(tgt.gaddr, {4'h5, 14'h0122})
		dbg_page_en <= 0;
		dbg(16'h8000, 0, 0);
		dbg(16'hFF00, 1, 1);
		dbg(16'hFF00, 0, 0);
		@(posedge clk);
		call_page_we <= 1;
		call_page_data <= 4'hF;
		@(posedge clk);
		call_page_we <= 0;
		#1;
		page = 4'hF;
		`CHK(pps, 4'hF)
		dbg(16'hBF20, 1, 1);
		cpu_req <= '{1'b1, 1'b0, 1'b0, 16'hC000};
		dbg(16'hFF00, 1, 1);
		cpu_req.valid <= 0;
		`CHK(waited inside {[129:140]}, 1'b1)
		repeat (300) begin
			r = rnd();
			if (r[7:4] == 4'h0) begin
				apb(1, 32'h54, {28'h0, r[3:0]});
				page = r[3:0];
			end
			cpu(r[31:16]);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
